// [core/gpp_defs.svh]
// Register offsets, field positions, reset values and sizes of the GPIO port block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

`define GPP_NUM_PORTS      4
`define GPP_PORT_WIDTH     8
`define GPP_PORT_STRIDE    12'h010
`define GPP_OFF_OUT_DATA   12'h000
`define GPP_OFF_DIRECTION  12'h004
`define GPP_OFF_INPUT      12'h008
`define GPP_OFF_SET        12'h00C
`define GPP_OFF_SPECIAL    12'h100
`define GPP_OFF_BITOP      12'h104
`define GPP_OFF_SLEEP      12'h108
`define GPP_SPECIAL_PUD    0
`define GPP_BITOP_SET      0
`define GPP_BITOP_TGT_LSB  1
`define GPP_BITOP_PIN_LSB  4
`define GPP_BITOP_PORT_LSB 8
`define GPP_RESET_DATA     8'h00
`define GPP_RESP_OKAY      2'h0
`define GPP_RESP_SLVERR    2'h2
`define GPP_ADDR_WIDTH     12

`endif

// [core/gpp_pkg.sv]
// Types shared by the GPIO port block.
// Assumes the constants header is on the include path.
`include "gpp_defs.svh"

package gpp_pkg;
  typedef logic [`GPP_PORT_WIDTH-1:0]                        gpp_port_t;
  typedef logic [`GPP_NUM_PORTS-1:0][`GPP_PORT_WIDTH-1:0]    gpp_bus_t;
  typedef logic [`GPP_ADDR_WIDTH-1:0]                        gpp_addr_t;
  typedef enum logic [1:0] {
    GPP_BIT_DIRECTION = 2'h0,
    GPP_BIT_OUT_DATA  = 2'h1,
    GPP_BIT_PUD       = 2'h2,
    GPP_BIT_NONE      = 2'h3
  } gpp_bit_target_e;
endpackage

// [core/gpp_port.sv]
// GPIO port block: per-port data, direction and input registers behind AXI4-Lite.
// Assumes one clock, synchronous active-low reset, and pads resolved outside.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_defs.svh"

module gpp_port (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // AXI4-Lite write address and data.
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Pins.
  input  wire gpp_pkg::gpp_bus_t  pin_in,
  output gpp_pkg::gpp_bus_t       pin_out,
  output gpp_pkg::gpp_bus_t       pin_oe,
  output gpp_pkg::gpp_bus_t       pin_pullup_en,
  // Alternate-function override, one bit per pin.
  input  wire gpp_pkg::gpp_bus_t  alt_oe_override,
  input  wire gpp_pkg::gpp_bus_t  alt_oe_value,
  input  wire gpp_pkg::gpp_bus_t  alt_out_override,
  input  wire gpp_pkg::gpp_bus_t  alt_out_value,
  input  wire gpp_pkg::gpp_bus_t  alt_input_keep,
  // Deep sleep from the power controller.
  input  wire logic               deep_sleep
);
  import gpp_pkg::*;

  // ------------------------------------------------------------
  // Register map and usage notes
  // ------------------------------------------------------------
  // Port p occupies a 16-byte slot at 0x10 times p, for p from 0 to 3.
  // Offset 0x0 of a slot is the output data register, read and write.
  // Offset 0x4 of a slot is the direction register, read and write.
  // Offset 0x8 of a slot is the input register; writes to it are ignored.
  // Offset 0xC of a slot is unused and answers with a slave error.
  // Address 0x100 holds the global pull-up disable in bit 0.
  // Address 0x104 is the single-bit operation port and always reads zero.
  // Address 0x108 holds the deep-sleep clamp enable in bit 0.
  // Every other address answers with a slave error and reads zero.
  // Only the low byte of each word carries state; upper bits read zero.
  //
  // A bit operation word carries the value in bit 0, the target in bits 2:1,
  // the pin in bits 6:4 and the port in bits 9:8.
  // It must be written with both low byte strobes set, or it is dropped.
  // The target codes pick direction, output data, pull-up disable or nothing.
  // Software uses it where a read-modify-write of a whole byte could race
  // with another master changing a neighbouring pin.
  //
  // ------------------------------------------------------------
  // Bus timing
  // ------------------------------------------------------------
  // Address and data may arrive in either order or together.
  // Once both are held, the register changes at the next edge and the
  // response is raised at that same edge.
  // No new write is taken while a response waits for its ready.
  // A read returns its data one cycle after the address is taken.
  // No new read is taken while read data waits for its ready.
  // The readies are combinational so that a waiting master sees them at once.
  //
  // ------------------------------------------------------------
  // Pin behaviour
  // ------------------------------------------------------------
  // Direction one drives the pad; direction zero leaves it to the outside.
  // An input with data one gets the pull-up unless the global disable is set.
  // Software must step through an intermediate setting when moving a pin
  // between tri-state and driven high, or between pulled up and driven low.
  // This block does not enforce that order; a direct jump is carried out as
  // written and may disturb the pad for one cycle.
  // Reset floats every pad at once, without waiting for a clock edge.
  //
  // ------------------------------------------------------------
  // Input path
  // ------------------------------------------------------------
  // The latch and the input register form a two-stage synchroniser.
  // An outside change reaches the input register after a delay that
  // depends on where in the cycle it lands.
  // A value that this block drives reads back one period after the write edge,
  // so software must leave one idle cycle between the write and the read.
  // Deep sleep clamps the latch input low to keep floating pads from drawing
  // current; a pin whose keep input is high is left live.
  // The alternate-function inputs are taken as already synchronous.
  //
  // ------------------------------------------------------------
  // Limitations
  // ------------------------------------------------------------
  // Narrow strobes on byte writes are honoured only for the low byte.
  // A write that lands on the input register is answered with OKAY and dropped.
  // Reads of the bit operation port return zero so that software cannot
  // mistake it for state.

  gpp_bus_t   port_output_data_reg;
  gpp_bus_t   port_direction_reg;
  gpp_bus_t   port_input_reg;
  gpp_bus_t   sync_latch;
  gpp_bus_t   clamped_in;
  logic       global_pullup_disable;
  logic       sleep_clamp_en;

  // ------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  gpp_addr_t  aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       wr_hit;
  logic [1:0] wr_port;
  gpp_addr_t  wr_off;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_port       = aw_addr[5:4];
  assign wr_off        = aw_addr & 12'h00F;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Bit operation decode: one pin, one target, set or clear.
  gpp_bit_target_e bit_tgt;
  logic [2:0]      bit_pin;
  logic [1:0]      bit_port;
  logic            bit_val;
  logic            bit_fire;
  assign bit_tgt  = gpp_bit_target_e'(w_data[`GPP_BITOP_TGT_LSB +: 2]);
  assign bit_pin  = w_data[`GPP_BITOP_PIN_LSB +: 3];
  assign bit_port = w_data[`GPP_BITOP_PORT_LSB +: 2];
  assign bit_val  = w_data[`GPP_BITOP_SET];
  assign bit_fire = wr_fire && aw_addr == `GPP_OFF_BITOP && w_strb[1:0] == 2'h3;

  always_comb begin
    wr_hit = 1'b0;
    if (aw_addr < 12'h040 && aw_addr[1:0] == 2'h0 &&
        (wr_off == `GPP_OFF_OUT_DATA || wr_off == `GPP_OFF_DIRECTION || wr_off == `GPP_OFF_INPUT)) begin
      wr_hit = 1'b1;
    end else if (aw_addr == `GPP_OFF_SPECIAL || aw_addr == `GPP_OFF_BITOP || aw_addr == `GPP_OFF_SLEEP) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Port registers
  // ------------------------------------------------------------
  // Whole-byte writes hit one port only; bit operations touch at most one pin.
  genvar gp;
  generate
    for (gp = 0; gp < `GPP_NUM_PORTS; gp++) begin : g_port
      logic byte_wr;
      logic bit_here;
      assign byte_wr  = wr_fire && aw_addr < 12'h040 && wr_port == 2'(gp) && w_strb[0];
      assign bit_here = bit_fire && bit_port == 2'(gp);

      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          port_output_data_reg[gp] <= `GPP_RESET_DATA;
        end else if (byte_wr && wr_off == `GPP_OFF_OUT_DATA) begin
          port_output_data_reg[gp] <= w_data[7:0];
        end else if (bit_here && bit_tgt == GPP_BIT_OUT_DATA) begin
          port_output_data_reg[gp][bit_pin] <= bit_val;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          port_direction_reg[gp] <= `GPP_RESET_DATA;
        end else if (byte_wr && wr_off == `GPP_OFF_DIRECTION) begin
          port_direction_reg[gp] <= w_data[7:0];
        end else if (bit_here && bit_tgt == GPP_BIT_DIRECTION) begin
          port_direction_reg[gp][bit_pin] <= bit_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      global_pullup_disable <= 1'b0;
    end else if (wr_fire && aw_addr == `GPP_OFF_SPECIAL && w_strb[0]) begin
      global_pullup_disable <= w_data[`GPP_SPECIAL_PUD];
    end else if (bit_fire && bit_tgt == GPP_BIT_PUD) begin
      global_pullup_disable <= bit_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleep_clamp_en <= 1'b1;
    end else if (wr_fire && aw_addr == `GPP_OFF_SLEEP && w_strb[0]) begin
      sleep_clamp_en <= w_data[0];
    end
  end

  // ------------------------------------------------------------
  // Pin drive and input path
  // ------------------------------------------------------------
  // Reset gates the drivers combinationally so pins float with no clock.
  genvar gb;
  generate
    for (gb = 0; gb < `GPP_NUM_PORTS * `GPP_PORT_WIDTH; gb++) begin : g_pin
      localparam int P = gb / `GPP_PORT_WIDTH;
      localparam int B = gb % `GPP_PORT_WIDTH;
      logic drive;
      assign drive = alt_oe_override[P][B] ? alt_oe_value[P][B] : port_direction_reg[P][B];
      assign pin_oe[P][B] = reset_n && drive;
      assign pin_out[P][B] = alt_out_override[P][B] ? alt_out_value[P][B]
                                                    : port_output_data_reg[P][B];
      assign pin_pullup_en[P][B] = reset_n && !drive && port_output_data_reg[P][B]
                                   && !global_pullup_disable;
      // Deep sleep forces a low ahead of the latch to stop floating-input current.
      assign clamped_in[P][B] = pin_in[P][B] && !(deep_sleep && sleep_clamp_en
                                                  && !alt_input_keep[P][B]);
    end
  endgenerate

  // Transparent while the clock is high; the held value moves into the input
  // register at the next rising edge, so a pin write reads back one period later.
  always_latch begin
    if (sys_clk) begin
      sync_latch <= clamped_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      port_input_reg <= '0;
    end else begin
      port_input_reg <= sync_latch;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [1:0]  rd_port;
  gpp_addr_t   rd_off;
  assign rd_port       = s_axi_araddr[5:4];
  assign rd_off        = s_axi_araddr & 12'h00F;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr < 12'h040 && rd_off == `GPP_OFF_OUT_DATA) begin
      rd_word[7:0] = port_output_data_reg[rd_port];
    end else if (s_axi_araddr < 12'h040 && rd_off == `GPP_OFF_DIRECTION) begin
      rd_word[7:0] = port_direction_reg[rd_port];
    end else if (s_axi_araddr < 12'h040 && rd_off == `GPP_OFF_INPUT) begin
      rd_word[7:0] = port_input_reg[rd_port];
    end else if (s_axi_araddr == `GPP_OFF_SPECIAL) begin
      rd_word[`GPP_SPECIAL_PUD] = global_pullup_disable;
    end else if (s_axi_araddr == `GPP_OFF_SLEEP) begin
      rd_word[0] = sleep_clamp_en;
    end else if (s_axi_araddr != `GPP_OFF_BITOP) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `GPP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [bench/gpp_port_assertions.sv]
// Checker for the GPIO port block: bus handshakes and pad control at its ports.
// Assumes it is bound to every instance of the port block.
`timescale 1ns/10ps
`default_nettype none

module gpp_port_assertions (
  // Clock and reset.
  input wire logic              sys_clk,
  input wire logic              reset_n,
  // Bus handshakes.
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Pads.
  input wire gpp_pkg::gpp_bus_t pin_oe,
  input wire gpp_pkg::gpp_bus_t pin_pullup_en
);
  import gpp_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Reset must release the pads even though every other check is off during it.
  a_reset_tristate: assert property (disable iff (1'b0) !reset_n |-> pin_oe == '0 && pin_pullup_en == '0)
    else $error("pads not released during reset");
  a_pull_not_out: assert property ((pin_oe & pin_pullup_en) == '0)
    else $error("pull-up on a driven pin");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after the request");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after the address");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response waits");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data waits");
endmodule

bind gpp_port gpp_port_assertions u_gpp_port_assertions (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pin_oe, .pin_pullup_en);
`default_nettype wire

// [bench/gpp_pad_model.sv]
// Pad model: outside circuitry on the port pins, pull-ups and floating lines.
// Assumes the bench chooses which pins it drives and to what level.
`timescale 1ns/10ps
`default_nettype none

module gpp_pad_model (
  // Clock for the floating-line pattern.
  input  wire logic              sys_clk,
  // Block side of the pads.
  input  wire gpp_pkg::gpp_bus_t pin_out,
  input  wire gpp_pkg::gpp_bus_t pin_oe,
  input  wire gpp_pkg::gpp_bus_t pin_pullup_en,
  // Outside drivers set by the bench.
  input  wire gpp_pkg::gpp_bus_t ext_en,
  input  wire gpp_pkg::gpp_bus_t ext_val,
  // Level seen back at the block.
  output gpp_pkg::gpp_bus_t      pin_in
);
  import gpp_pkg::*;
  logic flip = 1'b0;

  // An undriven line toggles every cycle, so a missing pull-up cannot pass by luck.
  always @(posedge sys_clk) flip <= ~flip;

  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & pin_pullup_en)
           | (~pin_oe & ~ext_en & ~pin_pullup_en & {32{flip}});
  end
endmodule
`default_nettype wire

// [bench/gpp_port_tb_top.sv]
// Bench for the GPIO port block: register traffic over AXI4-Lite and pad checks.
// Assumes the pad model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module gpp_port_tb_top;
  import gpp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, deep_sleep = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  gpp_bus_t    pin_in, pin_out, pin_oe, pin_pullup_en;
  gpp_bus_t    ext_en = {4{8'hF1}}, ext_val = {4{8'h51}};
  gpp_bus_t    alt_oe_override = '0, alt_oe_value = '0, alt_out_override = '0, alt_out_value = '0;
  gpp_bus_t    alt_input_keep = '0;
  int          fails = 0;
  int          check_count = 0;

  always #4 sys_clk = ~sys_clk;

  gpp_port dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .pin_pullup_en, .alt_oe_override, .alt_oe_value, .alt_out_override, .alt_out_value, .alt_input_keep,
    .deep_sleep);
  gpp_pad_model pads (.sys_clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in);

  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Each task ends one edge past its handshake so the next call never reassigns in the same step.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    ck("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    ck("rdata", e, s_axi_rdata);
    ck("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge sys_clk);
  endtask

  // Data before direction, so no pin jumps straight between the forbidden pairs.
  task automatic t_modes();
    for (int p = 0; p < 4; p++) begin
      wr(12'(16 * p), 32'h0A, 2'h0);
      wr(12'(16 * p + 4), 32'h0C, 2'h0);
      ck("oe", 32'h0C, 32'(pin_oe[p]));
      ck("out", 32'h08, 32'(pin_out[p] & pin_oe[p]));
      ck("pull", 32'h02, 32'(pin_pullup_en[p]));
      rd(12'(16 * p + 8), 32'h5B, 2'h0);
      rd(12'(16 * p), 32'h0A, 2'h0);
    end
  endtask

  task automatic t_pud_bits();
    wr(12'h100, 32'h1, 2'h0);
    ck("pud", 32'h0, pin_pullup_en);
    rd(12'h100, 32'h1, 2'h0);
    wr(12'h100, 32'h0, 2'h0);
    wr(12'h104, 32'h143, 2'h0);
    wr(12'h104, 32'h120, 2'h0);
    wr(12'h104, 32'h5, 2'h0);
    ck("bit_pud", 32'h0, pin_pullup_en);
    wr(12'h104, 32'h4, 2'h0);
    wr(12'h104, 32'h7, 2'h0);
    ck("pull_mix", 32'h02021202, pin_pullup_en);
    rd(12'h010, 32'h1A, 2'h0);
    rd(12'h014, 32'h08, 2'h0);
    rd(12'h024, 32'h0C, 2'h0);
    rd(12'h104, 32'h0, 2'h0);
    wr(12'h008, 32'hFF, 2'h0);
    rd(12'h008, 32'h5B, 2'h0);
    wr(12'h200, 32'h1, 2'h2);
    rd(12'h200, 32'h0, 2'h2);
  endtask

  task automatic t_alt_sleep();
    {alt_oe_override[0], alt_oe_value[0], alt_out_override[0]} <= {3{8'h01}};
    repeat (2) @(posedge sys_clk);
    ck("alt_oe", 32'h0D, 32'(pin_oe[0]));
    ck("alt_out", 32'h08, 32'(pin_out[0] & pin_oe[0]));
    {alt_oe_override[0], alt_oe_value[0], alt_out_override[0], alt_input_keep[0], deep_sleep} <= {32'h1, 1'b1};
    repeat (3) @(posedge sys_clk);
    rd(12'h008, 32'h01, 2'h0);
    {alt_input_keep[0], deep_sleep} <= 9'h0;
    repeat (3) @(posedge sys_clk);
    rd(12'h008, 32'h5B, 2'h0);
  endtask

  task automatic t_rerun();
    reset_n <= 1'b0;
    #1;
    ck("oe_rst", 32'h0, pin_oe);
    ck("pull_rst", 32'h0, pin_pullup_en);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(12'h010, 32'h0, 2'h0);
    rd(12'h024, 32'h0, 2'h0);
    rd(12'h108, 32'h1, 2'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_modes();
    t_pud_bits();
    t_alt_sleep();
    t_rerun();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
